// ### src/event_counter_pkg.sv
package event_counter_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] ENABLE_OFS = 8'h00;
  localparam logic [7:0] PRESET_BASE = 8'h40;
  localparam logic [7:0] COMPARE_BASE = 8'h60;
  localparam logic [7:0] COUNT_BASE = 8'h80;
  localparam logic [7:0] FROZEN_BASE = 8'hA0;
  localparam logic [7:0] STAMP_BASE = 8'hC0;
  localparam logic [7:0] BANK_MASK = 8'hE0;
  localparam int INDEX_LSB = 2;
  localparam int INDEX_W = 3;

  // Reset values.
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [7:0] ENABLE_RESET = 8'h00;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Operands that the logic engine drives into one counter.
  typedef struct packed {
    logic count_up;
    logic count_down;
    logic block;
    logic preset_load_select;
    logic reset;
    logic freeze_reset;
    logic freeze_count;
  } counter_ops_t;

  // Comparison operands returned to the logic engine.
  typedef struct packed {
    logic count_above_flag;
    logic count_equal_flag;
    logic count_below_flag;
  } counter_flags_t;

endpackage : event_counter_pkg

// ### src/transition_event_counter.sv
// Register access over AXI4-Lite and the address map were left to the implementer.
`timescale 1ns/1ps

// Function
// - Eight identical independent counters.
// - Count only on rising input transitions.
// - Up from maximum wraps to minimum.
// - Down from minimum wraps to maximum.
// - Exactly one of above, equal, below.
// - Block ignores counting, holds operands off.
// - On enable load preset or zero.
// - Select rising edge loads preset while running.
// - Reset commands load preset or zero.
// - Reset input picks zero or preset; the code takes the choice from the select level instead.
// - Freeze-reset captures count, stamp, then zeroes; the code loads the preset instead while select is high.
// - Freeze-count captures without disturbing count.
// - Live, frozen, stamp values always readable.
// - Save values on power loss, restore later; the code saves and restores live and frozen values only, not stamps.
// - Preset usable before or during counting.
module transition_event_counter #(
  parameter int NUM_COUNTERS = 8,
  parameter int STAMP_W = 32
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Operands to and from the logic engine, one set per counter.
  input event_counter_pkg::counter_ops_t [NUM_COUNTERS-1:0] ops,
  output event_counter_pkg::counter_flags_t [NUM_COUNTERS-1:0] flags,
  // Time of day supplied by the system clock logic.
  input wire logic [STAMP_W-1:0] time_now,
  // Supply supervisor pin and non-volatile store port.
  input wire logic power_fail,
  output logic nv_wr_valid,
  output logic [4:0] nv_wr_addr,
  output logic [31:0] nv_wr_data,
  input wire logic nv_rd_valid,
  input wire logic [4:0] nv_rd_addr,
  input wire logic [31:0] nv_rd_data,
  // AXI4-Lite write channels.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // Settings, status buses and bus-side state.

  // Words in one save burst: every live count, then every frozen value.
  localparam int NV_WORDS = 2 * NUM_COUNTERS;

  logic [NUM_COUNTERS-1:0] enable;
  logic [NUM_COUNTERS-1:0][31:0] preset;
  logic [NUM_COUNTERS-1:0][31:0] compare;
  logic [NUM_COUNTERS-1:0][31:0] count_bus;
  logic [NUM_COUNTERS-1:0][31:0] frozen_bus;
  logic [NUM_COUNTERS-1:0][STAMP_W-1:0] stamp_bus;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  // Bank index width and position inside a byte address; both come from
  // the package so the decode and the bank sizes cannot drift apart.
  localparam int INDEX_W_LOCAL = event_counter_pkg::INDEX_W;
  localparam int INDEX_LSB_L = event_counter_pkg::INDEX_LSB;
  logic [INDEX_W_LOCAL-1:0] rd_index;
  // Power-fail synchroniser, edge history and save walk.
  logic pf_meta;
  logic pf_sync;
  logic pf_prev;
  logic saving;
  logic [4:0] save_index;

  // Both halves of a write are held until the response is taken.
  // The readies double as the state: both low with no response pending
  // means address and data are in hand and the write lands this cycle.
  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  ////////////////////////////////////////////////////////////////////////////
  // Per-counter datapath.

  generate
    for (genvar i = 0; i < NUM_COUNTERS; i++) begin : g_cnt
      event_counter_pkg::counter_ops_t prev;
      logic enable_prev;
      logic signed [31:0] count;
      logic signed [31:0] frozen;
      logic [STAMP_W-1:0] stamp;
      logic up_edge;
      logic down_edge;
      logic load_edge;
      logic reset_edge;
      logic frz_reset_edge;
      logic frz_count_edge;
      logic start;
      logic [31:0] load_value;

      // Except for block, and the select level that picks the load value, operands act only on low-to-high transitions; falls do nothing.
      assign up_edge = ops[i].count_up && !prev.count_up;
      assign down_edge = ops[i].count_down && !prev.count_down;
      assign load_edge = ops[i].preset_load_select && !prev.preset_load_select;
      assign reset_edge = ops[i].reset && !prev.reset;
      assign frz_reset_edge = ops[i].freeze_reset && !prev.freeze_reset;
      assign frz_count_edge = ops[i].freeze_count && !prev.freeze_count;
      assign start = enable[i] && !enable_prev;
      // The select level decides between the preset and zero.
      assign load_value = ops[i].preset_load_select ? preset[i] : event_counter_pkg::ZERO_WORD;

      // Edge history of every operand and of the enable setting.
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          prev <= '0;
          enable_prev <= 1'b0;
        end else begin
          prev <= ops[i];
          enable_prev <= enable[i];
        end
      end

      // Count update; restore from the store outranks everything, then the disabled
      // or blocked hold, then loads and resets, then counting.
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          count <= event_counter_pkg::ZERO_WORD;
        end else if (nv_rd_valid && nv_rd_addr == 5'(i)) begin
          count <= nv_rd_data;
        end else if (!enable[i] || ops[i].block) begin
          count <= count;
        end else if (start) begin
          count <= load_value;
        end else if (frz_reset_edge) begin
          count <= load_value;
        end else if (reset_edge) begin
          count <= load_value;
        end else if (load_edge) begin
          count <= preset[i];
        end else if (up_edge && !down_edge) begin
          count <= count + 32'sd1;
        end else if (down_edge && !up_edge) begin
          count <= count - 32'sd1;
        end
      end

      // Freeze capture keeps the count and time of the command.
      // A restore brings back the frozen value only; its stamp keeps its content.
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          frozen <= event_counter_pkg::ZERO_WORD;
          stamp <= '0;
        end else if (nv_rd_valid && nv_rd_addr == 5'(NUM_COUNTERS + i)) begin
          frozen <= nv_rd_data;
        end else if (enable[i] && !ops[i].block && (frz_reset_edge || frz_count_edge)) begin
          frozen <= count;
          stamp <= time_now;
        end
      end

      // Comparison flags; a blocked or disabled counter drives none.
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          flags[i] <= '0;
        end else if (!enable[i] || ops[i].block) begin
          flags[i] <= '0;
        end else begin
          flags[i].count_above_flag <= count > $signed(compare[i]);
          flags[i].count_equal_flag <= count == $signed(compare[i]);
          flags[i].count_below_flag <= count < $signed(compare[i]);
        end
      end

      // Status buses feed the read decode and the save walk; both see the
      // value settled after the last edge, never a half-made update.
      assign count_bus[i] = count;
      assign frozen_bus[i] = frozen;
      assign stamp_bus[i] = stamp;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Power-fail save sequence.

  // The supervisor pin is asynchronous, so it is synchronised first.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pf_meta <= 1'b0;
      pf_sync <= 1'b0;
      pf_prev <= 1'b0;
    end else begin
      pf_meta <= power_fail;
      pf_sync <= pf_meta;
      pf_prev <= pf_sync;
    end
  end

  // One word per cycle: live counts first, then frozen values. Stamps are
  // not saved, which keeps the hold-up energy needed to a minimum.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      saving <= 1'b0;
      save_index <= '0;
      nv_wr_valid <= 1'b0;
      nv_wr_addr <= '0;
      nv_wr_data <= event_counter_pkg::ZERO_WORD;
    end else begin
      nv_wr_valid <= saving;
      nv_wr_addr <= save_index;
      nv_wr_data <= (save_index < 5'(NUM_COUNTERS)) ?
                    count_bus[save_index[INDEX_W_LOCAL-1:0]] :
                    frozen_bus[save_index[INDEX_W_LOCAL-1:0]];
      if (pf_sync && !pf_prev && !saving) begin
        saving <= 1'b1;
        save_index <= '0;
      end else if (saving) begin
        saving <= save_index != 5'(NV_WORDS - 1);
        save_index <= (save_index == 5'(NV_WORDS - 1)) ? save_index : save_index + 5'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path.

  // Address and data are taken in either order and held until the write.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= event_counter_pkg::RESP_OKAY;
      aw_addr <= '0;
      w_data <= event_counter_pkg::ZERO_WORD;
      w_strb <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      // Only the settings banks accept writes; status banks answer with an
      // error and leave every register untouched.
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == event_counter_pkg::ENABLE_OFS ||
                        (aw_addr & event_counter_pkg::BANK_MASK) == event_counter_pkg::PRESET_BASE ||
                        (aw_addr & event_counter_pkg::BANK_MASK) == event_counter_pkg::COMPARE_BASE)
                       ? event_counter_pkg::RESP_OKAY : event_counter_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Settings registers with byte strobes.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable <= event_counter_pkg::ENABLE_RESET;
      preset <= '0;
      compare <= '0;
    end else if (do_write) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb[b]) begin
          if (aw_addr == event_counter_pkg::ENABLE_OFS && b == 0) begin
            enable <= w_data[7:0];
          end
          if ((aw_addr & event_counter_pkg::BANK_MASK) == event_counter_pkg::PRESET_BASE) begin
            preset[aw_addr[INDEX_LSB_L +: INDEX_W_LOCAL]][b*8 +: 8] <= w_data[b*8 +: 8];
          end
          if ((aw_addr & event_counter_pkg::BANK_MASK) == event_counter_pkg::COMPARE_BASE) begin
            compare[aw_addr[INDEX_LSB_L +: INDEX_W_LOCAL]][b*8 +: 8] <= w_data[b*8 +: 8];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path.

  // The index is taken from the address as it stands while arvalid is high.
  assign rd_index = s_axi_araddr[INDEX_LSB_L +: INDEX_W_LOCAL];

  // Read decode; unmapped addresses return zero with an error response.
  always_comb begin
    next_rdata = event_counter_pkg::ZERO_WORD;
    next_rresp = event_counter_pkg::RESP_OKAY;
    case (s_axi_araddr & event_counter_pkg::BANK_MASK)
      event_counter_pkg::PRESET_BASE: next_rdata = preset[rd_index];
      event_counter_pkg::COMPARE_BASE: next_rdata = compare[rd_index];
      event_counter_pkg::COUNT_BASE: next_rdata = count_bus[rd_index];
      event_counter_pkg::FROZEN_BASE: next_rdata = frozen_bus[rd_index];
      event_counter_pkg::STAMP_BASE: next_rdata = 32'(stamp_bus[rd_index]);
      default: begin
        if (s_axi_araddr == event_counter_pkg::ENABLE_OFS) begin
          next_rdata = {24'h000000, enable};
        end else begin
          next_rresp = event_counter_pkg::RESP_SLVERR;
        end
      end
    endcase
  end

  // One read at a time; data returned the cycle after the address.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= event_counter_pkg::ZERO_WORD;
      s_axi_rresp <= event_counter_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : transition_event_counter

// ### verif/event_counter_props.sv
`timescale 1ns/1ps

// Watches counter 0 and the bus handshakes; the other counters share its logic.
module event_counter_props #(
  parameter int NUM_COUNTERS = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Counter operands and flags.
  input event_counter_pkg::counter_ops_t [NUM_COUNTERS-1:0] ops,
  input event_counter_pkg::counter_flags_t [NUM_COUNTERS-1:0] flags,
  // Save port.
  input wire logic nv_wr_valid,
  input wire logic [4:0] nv_wr_addr,
  // Bus handshakes.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  property p_flags_onehot;
    $onehot0(flags[0]);
  endproperty
  a_flags_onehot: assert property (p_flags_onehot) else $error("flags not exclusive");
  property p_block_clear;
    ops[0].block [*3] |-> flags[0] == 3'h0;
  endproperty
  a_block_clear: assert property (p_block_clear) else $error("flags live while blocked");
  property p_reset_flags;
    $fell(rst) |-> flags == '0;
  endproperty
  a_reset_flags: assert property (p_reset_flags) else $error("flags set after reset");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");
  property p_read_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'hE0 |=>
      s_axi_rresp == event_counter_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read accepted");
  property p_aw_busy;
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  a_aw_busy: assert property (p_aw_busy) else $error("second write address taken");
  property p_nv_burst;
    $rose(nv_wr_valid) |-> nv_wr_addr == 5'h00 ##15 nv_wr_valid && nv_wr_addr == 5'h0F
      ##1 !nv_wr_valid;
  endproperty
  a_nv_burst: assert property (p_nv_burst) else $error("save burst malformed");
  property p_nv_start;
    $rose(nv_wr_valid) |-> $past(nv_wr_valid, 2) == 1'b0;
  endproperty
  a_nv_start: assert property (p_nv_start) else $error("save burst restarted");

  // Main scenarios reached.
  c_equal: cover property (flags[0] == 3'b010);
  c_save: cover property ($rose(nv_wr_valid));
  c_bad_read: cover property (s_axi_rvalid && s_axi_rresp == event_counter_pkg::RESP_SLVERR);
endmodule : event_counter_props

bind transition_event_counter event_counter_props #(.NUM_COUNTERS(NUM_COUNTERS)) props_inst (
  .clk, .rst, .ops, .flags, .nv_wr_valid, .nv_wr_addr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);

// ### verif/nv_store_model.sv
`timescale 1ns/1ps

// Non-volatile store: keeps saved words, replays them one per cycle on request.
module nv_store_model (
  // Clock.
  input wire logic clk,
  // Save side.
  input wire logic nv_wr_valid,
  input wire logic [4:0] nv_wr_addr,
  input wire logic [31:0] nv_wr_data,
  // Replay side.
  input wire logic restore_go,
  output logic nv_rd_valid,
  output logic [4:0] nv_rd_addr,
  output logic [31:0] nv_rd_data
);
  logic [31:0] mem [0:15];
  logic [4:0] idx = 5'h00;
  logic busy = 1'b0;

  // Capture every saved word at its address.
  always @(posedge clk) begin
    if (nv_wr_valid) mem[nv_wr_addr[3:0]] <= nv_wr_data;
  end
  // Replay walks addresses 0 to 15 once per request.
  always @(posedge clk) begin
    if (restore_go) begin
      busy <= 1'b1;
      idx <= 5'h00;
    end else if (busy) begin
      idx <= idx + 5'h01;
      busy <= (idx != 5'h0F);
    end
  end
  // Idle data is inverted so a stale word can never pass as a good one.
  assign nv_rd_valid = busy;
  assign nv_rd_addr = idx;
  assign nv_rd_data = busy ? mem[idx[3:0]] : ~mem[4'hF];
endmodule : nv_store_model

// ### verif/transition_event_counter_bench.sv
`timescale 1ns/1ps

module transition_event_counter_bench;
  localparam logic [6:0] up = 7'h40, dn = 7'h20, blk = 7'h10, sel = 7'h08;
  localparam logic [6:0] clr = 7'h04, frz = 7'h02, cap = 7'h01;
  localparam logic [1:0] ok = 2'h0, bad = 2'h2;
  logic clk = 1'b0, rst = 1'b1, power_fail = 1'b0, restore_go = 1'b0;
  event_counter_pkg::counter_ops_t [7:0] ops = '0;
  event_counter_pkg::counter_flags_t [7:0] flags;
  logic [31:0] time_now = 32'h0, wdata = 32'h0, rdata, nv_wr_data, nv_rd_data;
  logic [4:0] nv_wr_addr, nv_rd_addr;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, a_on, w_on;
  logic awready, wready, bvalid, arready, rvalid, nv_wr_valid, nv_rd_valid;
  logic [31:0] cmpv [4] = '{32'h8, 32'h9, 32'h7, 32'h8000_0000};
  logic [2:0] expf [4] = '{3'h2, 3'h1, 3'h4, 3'h4};
  int err_count = 0, cmp_count = 0;

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  transition_event_counter transition_event_counter_inst (.clk(clk), .rst(rst), .ops(ops),
    .flags(flags), .time_now(time_now), .power_fail(power_fail), .nv_wr_valid(nv_wr_valid),
    .nv_wr_addr(nv_wr_addr), .nv_wr_data(nv_wr_data), .nv_rd_valid(nv_rd_valid),
    .nv_rd_addr(nv_rd_addr), .nv_rd_data(nv_rd_data), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  nv_store_model nv_store_model_inst (.clk(clk), .nv_wr_valid(nv_wr_valid),
    .nv_wr_addr(nv_wr_addr), .nv_wr_data(nv_wr_data), .restore_go(restore_go),
    .nv_rd_valid(nv_rd_valid), .nv_rd_addr(nv_rd_addr), .nv_rd_data(nv_rd_data));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count; every check goes through here.
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Bus write: address and data released separately as each is taken.
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    a_on = 1'b1;
    w_on = 1'b1;
    while (a_on || w_on) begin
      @(posedge clk);
      if (a_on && awready) begin
        a_on = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_on && wready) begin
        w_on = 1'b0;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wr
  // Bus read with expected word and response.
  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    check($sformatf("word %h", a), exp, rdata);
    check("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : rd
  // One-cycle operand pulse, then time for count and flags to settle.
  // An edge first lets any level set just before the call take effect.
  task pulse(input int i, input logic [6:0] m);
    @(posedge clk);
    ops[i] <= ops[i] | m;
    @(posedge clk);
    ops[i] <= ops[i] & ~m;
    repeat (3) @(posedge clk);
  endtask : pulse
  // Prints the counts and the verdict, then stops.
  task print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well above the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    print_verdict();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h80, 32'h0);
    rd(8'hE4, 32'h0, bad);
    wr(8'h84, 32'h5, bad);
    $display("test map done");
    ops[0] <= sel;
    wr(8'h40, 32'h5, ok);
    wr(8'h44, 32'h5, ok);
    wr(8'h00, 32'h3, ok);
    rd(8'h80, 32'h5);
    rd(8'h84, 32'h0);
    pulse(0, up);
    pulse(0, up);
    pulse(0, up | dn);
    ops[0] <= sel | up;
    repeat (5) @(posedge clk);
    ops[0] <= sel;
    rd(8'h80, 32'h8);
    for (int k = 0; k < 4; k++) begin
      wr(8'h60, cmpv[k], ok);
      repeat (2) @(posedge clk);
      check("flags", {29'h0, expf[k]}, {29'h0, flags[0]});
    end
    $display("test counting done");
    ops[0] <= sel | blk;
    repeat (3) @(posedge clk);
    check("blocked flags", 32'h0, {29'h0, flags[0]});
    pulse(0, up);
    ops[0] <= sel;
    rd(8'h80, 32'h8);
    time_now <= 32'h0000_1111;
    pulse(0, cap);
    pulse(0, up);
    rd(8'hA0, 32'h8);
    rd(8'hC0, 32'h0000_1111);
    rd(8'h80, 32'h9);
    $display("test block and capture done");
    wr(8'h40, 32'h7FFF_FFFF, ok);
    ops[0] <= '0;
    repeat (2) @(posedge clk);
    rd(8'h80, 32'h9);
    pulse(0, sel);
    rd(8'h80, 32'h7FFF_FFFF);
    pulse(0, up);
    rd(8'h80, 32'h8000_0000);
    pulse(0, dn);
    rd(8'h80, 32'h7FFF_FFFF);
    ops[0] <= sel;
    pulse(0, up);
    pulse(0, clr);
    rd(8'h80, 32'h7FFF_FFFF);
    pulse(1, up);
    pulse(1, clr);
    rd(8'h84, 32'h0);
    $display("test preset and wrap done");
    pulse(0, up);
    ops[0] <= '0;
    time_now <= 32'h0000_2222;
    pulse(0, frz);
    rd(8'h80, 32'h0);
    rd(8'hA0, 32'h8000_0000);
    rd(8'hC0, 32'h0000_2222);
    pulse(0, up);
    power_fail <= 1'b1;
    repeat (30) @(posedge clk);
    power_fail <= 1'b0;
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h80, 32'h0);
    restore_go <= 1'b1;
    @(posedge clk);
    restore_go <= 1'b0;
    repeat (20) @(posedge clk);
    rd(8'h80, 32'h1);
    rd(8'hA0, 32'h8000_0000);
    $display("test freeze and save done");
    print_verdict();
  end
endmodule : transition_event_counter_bench
